// ==== design/spw_pkg.sv ====
// Constants, types and helpers for the status and write-protect block.
// Assumes one core clock of 250 MHz and an SPI serial clock in modes 0 and 3.
package spw_pkg;

  // Opcodes, bit 3 is ignored when matching
  localparam logic [7:0] SPW_OP_MASK = 8'hF7;
  localparam logic [7:0] SPW_OP_SET_LATCH = 8'h06;
  localparam logic [7:0] SPW_OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] SPW_OP_RD_STATUS = 8'h05;
  localparam logic [7:0] SPW_OP_WR_STATUS = 8'h01;

  // Frame lengths in serial bits
  localparam logic [4:0] SPW_BITS_OPCODE = 5'h08;
  localparam logic [4:0] SPW_BITS_WRITE_STATUS_CMD = 5'h10;
  localparam logic [4:0] SPW_CNT_LAST = 5'h1F;
  localparam logic [4:0] SPW_CNT_ONE = 5'h01;
  localparam logic [2:0] SPW_BYTE_LAST = 3'h7;

  // Status layout
  localparam logic [2:0] SPW_RSV_BUSY = 3'h7;
  localparam logic [2:0] SPW_RSV_IDLE = 3'h0;
  localparam int SPW_BIT_HW_PROTECT_ENABLE = 7;
  localparam int SPW_BIT_BP_HI = 3;
  localparam int SPW_BIT_BP_LO = 2;

  // Block protect levels and bounds
  localparam logic [1:0] SPW_BP_NONE = 2'h0;
  localparam logic [1:0] SPW_BP_QUARTER = 2'h1;
  localparam logic [1:0] SPW_BP_HALF = 2'h2;
  localparam logic [15:0] SPW_QUARTER_BASE = 16'hC000;
  localparam logic [15:0] SPW_HALF_BASE = 16'h8000;

  // Self-timed write cycle: longest time, rounded down
  localparam int SPW_WRITE_CYCLE_TIME_NS = 5000000;
  localparam int SPW_CLK_PERIOD_NS = 4;
  localparam int SPW_WRITE_CYCLE_CLKS = SPW_WRITE_CYCLE_TIME_NS / SPW_CLK_PERIOD_NS;
  localparam int SPW_TMR_W = 21;
  localparam logic [SPW_TMR_W-1:0] SPW_TMR_ONE = 21'h000001;

  typedef struct packed {
    logic hw_protect_enable;
    logic [2:0] reserved_bits;
    logic block_protect_hi;
    logic block_protect_lo;
    logic write_enable_latch;
    logic ready_busy_flag;
  } spw_status_s;

  // Serial frame as seen at chip select release
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0] count;
    logic overrun;
  } spw_frame_s;

  typedef enum logic [1:0] {
    SPW_ST_IDLE = 2'b00,
    SPW_ST_WRITE = 2'b01,
    SPW_ST_COMMIT = 2'b11
  } spw_state_e;

  function automatic logic spw_op_is(input logic [7:0] op, input logic [7:0] code);
    return (op & SPW_OP_MASK) == code;
  endfunction

  function automatic logic spw_blk_protected(input logic [1:0] bp, input logic [15:0] addr);
    case (bp)
      SPW_BP_NONE: return 1'b0;
      SPW_BP_QUARTER: return addr >= SPW_QUARTER_BASE;
      SPW_BP_HALF: return addr >= SPW_HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction

endpackage

// ==== design/spw_status_protect.sv ====
// Status register, write-enable latch and write protection of a serial EEPROM.
// Assumes sck, cs_n, si, wp_n are raw pins; array requests come from core logic on clk.
// Contract
// - Status byte holds protect enable, reserved, block protect, latch and busy flag.
// - Reserved bits read zero when idle, ones during an internal write; here ones only in a status write cycle, zero while array_busy.
// - Busy flag reads one while an internal operation runs, else zero.
// - Latch reads one when writes enabled, clears at power-up, not writable.
// - Opcode 05h makes status shift out MSB first right after opcode.
// - Opcode 06h then chip select release sets the write-enable latch.
// - Status and array are only altered while the latch is one.
// - Opcode 04h clears the latch regardless of write-protect pin.
// - Status write changes only bits 7, 3 and 2.
// - Protect enable and block protect bits live in nonvolatile cells.
// - Valid status write starts a timed cycle at chip select release.
// - During that cycle every command but status read is ignored.
// - Latch clears when the status write cycle completes.
// - Block protect decodes to none, top quarter, top half or all.
// - Pin low with protect enable set blocks every status write.
// - Otherwise status writes need the latch set.
// - Protected addresses never written; others written when latch set; here also not during a status write cycle.
// - Protect enable cannot be cleared while pin stays low.
// - Opcodes match with bit 3 ignored.
// - Pin falling during a status write frame with protect enable set aborts it; later no effect.
module spw_status_protect
  import spw_pkg::*;
#(
  parameter int WRITE_CYCLES = SPW_WRITE_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_data,
  output logic so_oe,
  input wire logic [2:0] nv_cells_in,
  output logic [2:0] nv_wr_data,
  output logic nv_wr_pulse,
  input wire logic array_wr_req,
  input wire logic [15:0] array_wr_addr,
  input wire logic array_busy,
  output logic array_wr_ok,
  output spw_status_s status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain

  logic first_edge;
  logic [4:0] bit_cnt;
  logic overrun;
  logic [15:0] rx_shift;
  logic rd_mode;
  logic [7:0] tx_shift;
  spw_status_s st_meta;
  spw_status_s st_sync;
  logic [7:0] op_now;
  logic load_tx;

  // Chip select high rearms the frame without needing a serial edge
  always_ff @(posedge sck or posedge rst or posedge cs_n) begin
    if (rst || cs_n) begin
      first_edge <= 1'b1;
    end else begin
      first_edge <= 1'b0;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      bit_cnt <= '0;
      overrun <= 1'b0;
      rx_shift <= '0;
    end else begin
      rx_shift <= {rx_shift[14:0], si};
      if (first_edge) begin
        bit_cnt <= SPW_CNT_ONE;
        overrun <= 1'b0;
      end else begin
        bit_cnt <= bit_cnt + SPW_CNT_ONE;
        if (bit_cnt == SPW_CNT_LAST) begin
          overrun <= 1'b1;
        end
      end
    end
  end

  // Status snapshot ripens over the opcode bits of the frame
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      st_meta <= '0;
      st_sync <= '0;
    end else begin
      st_meta <= status_out;
      st_sync <= st_meta;
    end
  end

  assign op_now = {rx_shift[6:0], si};
  assign load_tx = !first_edge && bit_cnt[2:0] == SPW_BYTE_LAST;

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      rd_mode <= 1'b0;
    end else if (first_edge) begin
      rd_mode <= 1'b0;
    end else if (bit_cnt == SPW_BITS_OPCODE - SPW_CNT_ONE) begin
      rd_mode <= spw_op_is(op_now, SPW_OP_RD_STATUS);
    end
  end

  // Reload every byte so a held read repeats the status
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      tx_shift <= '0;
    end else if (load_tx) begin
      tx_shift <= st_sync;
    end else begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  always_ff @(negedge sck or posedge rst or posedge cs_n) begin
    if (rst || cs_n) begin
      so_oe <= 1'b0;
      so_data <= 1'b0;
    end else begin
      so_oe <= rd_mode;
      so_data <= tx_shift[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and frame synchronisers into clk

  logic [2:0] cs_sync;
  logic [2:0] wp_sync;
  spw_frame_s frame_meta;
  spw_frame_s frame_sync;
  logic cs_rise;
  logic cs_fall;
  logic wp_fall;
  logic wp_low;

  // Frame words are static once sck stops; cs delay covers their settling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync <= 3'h7;
      wp_sync <= 3'h7;
      frame_meta <= '0;
      frame_sync <= '0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n};
      wp_sync <= {wp_sync[1:0], wp_n};
      frame_meta <= '{shift: rx_shift, count: bit_cnt, overrun: overrun};
      frame_sync <= frame_meta;
    end
  end

  assign cs_rise = cs_sync[1] && !cs_sync[2];
  assign cs_fall = !cs_sync[1] && cs_sync[2];
  assign wp_fall = !wp_sync[1] && wp_sync[2];
  assign wp_low = !wp_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at chip select release

  logic len_opcode;
  logic len_write_status_cmd;
  logic [7:0] op_short;
  logic [7:0] op_long;
  logic hw_locked;
  logic wr_abort;
  spw_state_e state;
  logic busy;
  logic hw_protect_enable;
  logic [1:0] block_protect;
  logic write_enable_latch;
  logic nv_loaded;
  logic [2:0] nv_pending;
  logic [SPW_TMR_W-1:0] wc_timer;
  logic do_set;
  logic do_clr;
  logic do_write_status_cmd;

  assign len_opcode = !frame_sync.overrun && frame_sync.count == SPW_BITS_OPCODE;
  assign len_write_status_cmd = !frame_sync.overrun && frame_sync.count == SPW_BITS_WRITE_STATUS_CMD;
  assign op_short = frame_sync.shift[7:0];
  assign op_long = frame_sync.shift[15:8];
  assign busy = state != SPW_ST_IDLE;
  assign hw_locked = hw_protect_enable && wp_low;

  assign do_set = cs_rise && !busy && len_opcode && spw_op_is(op_short, SPW_OP_SET_LATCH);
  assign do_clr = cs_rise && !busy && len_opcode && spw_op_is(op_short, SPW_OP_CLR_LATCH);
  assign do_write_status_cmd = cs_rise && !busy && len_write_status_cmd && spw_op_is(op_long, SPW_OP_WR_STATUS)
                   && write_enable_latch && !hw_locked && !wr_abort;

  // Pin fall inside a frame with protect enable set spoils only that frame's status write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_abort <= 1'b0;
    end else if (wp_fall && !cs_sync[1] && hw_protect_enable) begin
      wr_abort <= 1'b1;
    end else if (cs_fall) begin
      wr_abort <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write cycle

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SPW_ST_IDLE;
      wc_timer <= '0;
      nv_pending <= '0;
    end else begin
      case (state)
        SPW_ST_IDLE: begin
          if (do_write_status_cmd) begin
            state <= SPW_ST_WRITE;
            wc_timer <= SPW_TMR_W'(WRITE_CYCLES);
            nv_pending <= {frame_sync.shift[SPW_BIT_HW_PROTECT_ENABLE], frame_sync.shift[SPW_BIT_BP_HI],
                           frame_sync.shift[SPW_BIT_BP_LO]};
          end
        end
        SPW_ST_WRITE: begin
          // Pin changes here no longer matter
          if (wc_timer <= SPW_TMR_ONE) begin
            state <= SPW_ST_COMMIT;
          end else begin
            wc_timer <= wc_timer - SPW_TMR_ONE;
          end
        end
        SPW_ST_COMMIT: begin
          state <= SPW_ST_IDLE;
        end
        default: begin
          state <= SPW_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile bits and write-enable latch

  // Cells hold the value across power; copied in once after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_loaded <= 1'b0;
      hw_protect_enable <= 1'b0;
      block_protect <= SPW_BP_NONE;
      nv_wr_data <= '0;
      nv_wr_pulse <= 1'b0;
    end else begin
      nv_loaded <= 1'b1;
      nv_wr_pulse <= 1'b0;
      if (!nv_loaded) begin
        {hw_protect_enable, block_protect} <= nv_cells_in;
        nv_wr_data <= nv_cells_in;
      end else if (state == SPW_ST_COMMIT) begin
        {hw_protect_enable, block_protect} <= nv_pending;
        nv_wr_data <= nv_pending;
        nv_wr_pulse <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (state == SPW_ST_COMMIT || do_clr) begin
      write_enable_latch <= 1'b0;
    end else if (do_set) begin
      write_enable_latch <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status image and array write gate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_out <= '0;
    end else begin
      status_out.hw_protect_enable <= hw_protect_enable;
      status_out.reserved_bits <= busy ? SPW_RSV_BUSY : SPW_RSV_IDLE;
      status_out.block_protect_hi <= block_protect[1];
      status_out.block_protect_lo <= block_protect[0];
      status_out.write_enable_latch <= write_enable_latch;
      status_out.ready_busy_flag <= busy || array_busy;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      array_wr_ok <= 1'b0;
    end else begin
      array_wr_ok <= array_wr_req && write_enable_latch && !busy
                     && !spw_blk_protected(block_protect, array_wr_addr);
    end
  end

endmodule // spw_status_protect

// ==== test/spw_host_model.sv ====
// SPI host model in mode 0, also owning the write-protect pin.
// Serial clock of 125 ns runs only inside frames.
module spw_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic wp_n,
  input wire logic so_data,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    wp_n = 1'b1;
  end
  //////////////////////////////////////////
  // MSB first; wf is the bit at which wp_n falls, -1 for none
  task automatic xfer(input logic [15:0] tx, input int n, input int wf,
    output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #31 si = tx[i];
      if (i == wf) wp_n = 1'b0;
      #31.5 sck = 1'b1;
      // Undriven output must never pass as data
      rx = {rx[14:0], so_oe ? so_data : 1'bx};
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si;
    #150;
  endtask
endmodule // spw_host_model

// ==== test/spw_status_protect_bench.sv ====
// Self-checking bench for the status and write-protect block.
// Host model drives the serial pins; array requests and cells live here.
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, a); end end
module spw_status_protect_bench
  import spw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 2500;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck, cs_n, si, wp_n, so_data, so_oe, nv_wr_pulse, array_wr_ok;
  logic [2:0] nv_wr_data;
  logic [2:0] cells = 3'h2;
  logic array_wr_req = 1'b0;
  logic [15:0] array_wr_addr = 16'h0000;
  logic array_busy = 1'b0;
  spw_status_s status_out;
  logic [15:0] rx;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  spw_status_protect #(.WRITE_CYCLES(WCYC)) dut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_data(so_data), .so_oe(so_oe), .nv_cells_in(cells), .nv_wr_data(nv_wr_data),
    .nv_wr_pulse(nv_wr_pulse), .array_wr_req(array_wr_req), .array_wr_addr(array_wr_addr),
    .array_busy(array_busy), .array_wr_ok(array_wr_ok), .status_out(status_out));
  spw_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_data(so_data),
    .so_oe(so_oe));
  always #2 clk = ~clk;
  // Cells keep their value across resets
  always @(posedge clk) if (nv_wr_pulse) cells <= nv_wr_data;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmd(input logic [15:0] tx, input int n = 8, input int wf = -1);
    host.xfer(tx, n, wf, rx);
  endtask
  task automatic rd(input logic [7:0] exp, input logic [7:0] op = 8'h05);
    host.xfer({op, 8'h00}, 16, -1, rx);
    `CHK("status", exp, rx[7:0])
  endtask
  task automatic gate(input logic [15:0] a, input logic exp);
    @(negedge clk);
    array_wr_req = 1'b1;
    array_wr_addr = a;
    @(negedge clk);
    `CHK("array_wr_ok", exp, array_wr_ok)
    array_wr_req = 1'b0;
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 4000 && status_out.ready_busy_flag !== 1'b0; i++) @(negedge clk);
  endtask
  //////////////////////////////////////////
  initial begin
    reset_dut();
    rd(8'h08);
    array_busy = 1'b1;
    rd(8'h09);
    array_busy = 1'b0;
    gate(16'h0000, 1'b0);
    $display("test reset done");
    cmd(16'h000E);
    rd(8'h0A, 8'h0D);
    gate(16'h7FFF, 1'b1);
    gate(16'h8000, 1'b0);
    cmd(16'h000C, 9);
    rd(8'h0A);
    cmd(16'h000C, 8, 7);
    rd(8'h08);
    host.wp_n = 1'b1;
    cmd(16'h018C, 16);
    rd(8'h08);
    $display("test latch done");
    cmd(16'h0006);
    cmd(16'h01FF, 16);
    cmd(16'h0004);
    rd(8'h7B);
    wait_idle();
    rd(8'h8C);
    cmd(16'h0006);
    gate(16'h0000, 1'b0);
    reset_dut();
    rd(8'h8C);
    $display("test status write done");
    cmd(16'h0006);
    host.wp_n = 1'b0;
    cmd(16'h0100, 16);
    rd(8'h8E);
    host.wp_n = 1'b1;
    cmd(16'h0100, 16, 4);
    rd(8'h8E);
    host.wp_n = 1'b1;
    cmd(16'h0900, 16);
    wait_idle();
    rd(8'h00);
    $display("test pin protect done");
    end_sim();
  end
endmodule // spw_status_protect_bench

// ==== test/spw_status_protect_monitor.sv ====
// Checker for the status and write-protect block.
// Sees only the top module ports; bound to every instance below.
module spw_status_protect_monitor
  import spw_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so_data,
  input wire logic so_oe,
  input wire logic [2:0] nv_cells_in,
  input wire logic [2:0] nv_wr_data,
  input wire logic nv_wr_pulse,
  input wire logic array_wr_req,
  input wire logic [15:0] array_wr_addr,
  input wire logic array_busy,
  input wire logic array_wr_ok,
  input wire spw_status_s status_out
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] bp;
  assign bp = {status_out.block_protect_hi, status_out.block_protect_lo};
  //////////////////////////////////////////
  a_rsv_idle: assert property (!status_out.ready_busy_flag |-> !status_out.reserved_bits)
    else $error("reserved bits set while ready");
  a_rsv_busy: assert property (|status_out.reserved_bits |->
    status_out.reserved_bits == 3'h7 && status_out.ready_busy_flag)
    else $error("reserved bits partial or busy flag low");
  a_busy_hold: assert property ($rose(status_out.reserved_bits[0]) |->
    status_out.ready_busy_flag [*8])
    else $error("write cycle ended too soon");
  a_commit_pulse: assert property (nv_wr_pulse |->
    status_out.reserved_bits == 3'h7 ##1 !nv_wr_pulse)
    else $error("store pulse outside write cycle");
  a_latch_clear: assert property (nv_wr_pulse |-> ##[1:3] !status_out.write_enable_latch)
    else $error("latch kept after write cycle");
  a_nv_data: assert property (nv_wr_pulse |->
    ##[1:3] {status_out.hw_protect_enable, bp} == nv_wr_data)
    else $error("protect bits differ from stored value");
  a_gate_req: assert property (array_wr_ok |-> $past(array_wr_req))
    else $error("array grant without request");
  a_gate_decode: assert property (array_wr_ok |-> status_out.write_enable_latch
    && bp != 2'h3 && !(bp == 2'h2 && $past(array_wr_addr) >= 16'h8000)
    && !(bp == 2'h1 && $past(array_wr_addr) >= 16'hC000))
    else $error("array grant in protected range");
  a_so_select: assert property (so_oe |-> !cs_n)
    else $error("serial output driven while deselected");
  c_store: cover property (nv_wr_pulse);
  c_grant: cover property (array_wr_ok);
  c_read: cover property (so_oe);
endmodule // spw_status_protect_monitor

bind spw_status_protect spw_status_protect_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon (
  .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_data(so_data),
  .so_oe(so_oe), .nv_cells_in(nv_cells_in), .nv_wr_data(nv_wr_data),
  .nv_wr_pulse(nv_wr_pulse), .array_wr_req(array_wr_req), .array_wr_addr(array_wr_addr),
  .array_busy(array_busy), .array_wr_ok(array_wr_ok), .status_out(status_out));
